/* hw/pmc_power_mode_controller.sv */
// Power mode controller: sleep sequencing, wake and clock gating
`timescale 1ns/1ps
module pmc_power_mode_controller (
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire logic                              clk_en,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [11:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  output logic                                   pready,
  output logic      [31:0]                       prdata,
  output logic                                   pslverr,
  input  wire logic                              sleep_req,
  input  wire logic                              wake_accept,
  input  wire logic [pmc_pkg::NUM_WAKE-1:0]      wake_src,
  input  wire logic [pmc_pkg::NUM_RST-1:0]       rst_src,
  output logic                                   core_run,
  output logic      [3:0]                        power_mode,
  output logic                                   flash_fetch,
  output logic                                   ram_fetch_nowait,
  output logic                                   wake_irq_pulse,
  output logic                                   deep_reset_req,
  output logic                                   ram_retain_only,
  output pmc_pkg::pmc_clk_t                      clk_ctrl,
  output logic      [pmc_pkg::NUM_PERIPH-1:0]    periph_clk_en
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [pmc_pkg::NUM_WAKE-1:0] wake_sync;
  logic [pmc_pkg::NUM_RST-1:0]  rst_sync;

  pmc_sync #(.W(pmc_pkg::NUM_WAKE)) u_wake_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (clk_en),
    .d       (wake_src),
    .q       (wake_sync)
  );

  pmc_sync #(.W(pmc_pkg::NUM_RST)) u_rst_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (clk_en),
    .d       (rst_src),
    .q       (rst_sync)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [4:0]                     ctrl_ff;
  logic [4:0]                     nxt_ctrl;
  logic [pmc_pkg::NUM_PERIPH-1:0] gate_ff;
  logic [pmc_pkg::NUM_PERIPH-1:0] nxt_gate;
  logic [pmc_pkg::NUM_WAKE-1:0]   wakeen_ff;
  logic [pmc_pkg::NUM_WAKE-1:0]   nxt_wakeen;
  logic [pmc_pkg::NUM_RST-1:0]    rsten_ff;
  logic [pmc_pkg::NUM_RST-1:0]    nxt_rsten;
  logic [31:0]                    prdata_ff;
  logic [31:0]                    nxt_prdata;
  logic                           slverr_ff;
  logic                           nxt_slverr;
  logic                           acc;
  logic                           hit;

  pmc_pkg::pmc_state_t state_ff;
  pmc_pkg::pmc_state_t nxt_state;
  logic [3:0]          mode_ff;
  logic [3:0]          nxt_mode;
  logic                wpulse_ff;
  logic                nxt_wpulse;
  logic                rstreq_ff;
  logic                nxt_rstreq;

  // Single-cycle APB: answer in the first access cycle
  assign acc    = psel & penable;
  assign pready = 1'b1;
  assign hit    = (paddr == pmc_pkg::ADDR_CTRL) | (paddr == pmc_pkg::ADDR_CLKGATE) |
                  (paddr == pmc_pkg::ADDR_WAKEEN) | (paddr == pmc_pkg::ADDR_RSTEN) |
                  (paddr == pmc_pkg::ADDR_STATUS);

  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_gate   = gate_ff;
    nxt_wakeen = wakeen_ff;
    nxt_rsten  = rsten_ff;
    nxt_prdata = prdata_ff;
    nxt_slverr = 1'b0;
    if (clk_en && acc) begin
      nxt_slverr = ~hit;
      if (pwrite) begin
        case (paddr)
          pmc_pkg::ADDR_CTRL:    nxt_ctrl   = pwdata[4:0];
          pmc_pkg::ADDR_CLKGATE: nxt_gate   = pwdata[pmc_pkg::NUM_PERIPH-1:0];
          pmc_pkg::ADDR_WAKEEN:  nxt_wakeen = pwdata[pmc_pkg::NUM_WAKE-1:0];
          pmc_pkg::ADDR_RSTEN:   nxt_rsten  = pwdata[pmc_pkg::NUM_RST-1:0];
          default:               nxt_ctrl   = ctrl_ff;
        endcase
      end else begin
        case (paddr)
          pmc_pkg::ADDR_CTRL:    nxt_prdata = {27'h0000000, ctrl_ff};
          pmc_pkg::ADDR_CLKGATE: nxt_prdata = {16'h0000, gate_ff};
          pmc_pkg::ADDR_WAKEEN:  nxt_prdata = {22'h000000, wakeen_ff};
          pmc_pkg::ADDR_RSTEN:   nxt_prdata = {28'h0000000, rsten_ff};
          pmc_pkg::ADDR_STATUS:  nxt_prdata = {23'h000000, state_ff, mode_ff};
          default:               nxt_prdata = 32'h00000000;
        endcase
      end
    end else if (!clk_en) begin
      nxt_slverr = slverr_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff   <= pmc_pkg::CTRL_RST;
      gate_ff   <= pmc_pkg::CLKGATE_RST;
      wakeen_ff <= pmc_pkg::WAKEEN_RST;
      rsten_ff  <= pmc_pkg::RSTEN_RST;
      prdata_ff <= 32'h00000000;
      slverr_ff <= 1'b0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      gate_ff   <= nxt_gate;
      wakeen_ff <= nxt_wakeen;
      rsten_ff  <= nxt_rsten;
      prdata_ff <= nxt_prdata;
      slverr_ff <= nxt_slverr;
    end
  end

  // Read data is driven combinationally from paddr in a read access cycle while clk_en is high;
  // at all other times, a read with clk_en low included, prdata shows prdata_ff, the last read value.
  assign prdata  = (acc && !pwrite) ? nxt_prdata : prdata_ff;
  assign pslverr = acc & ~hit;

  // ****************************************
  // Power mode sequencer
  // ****************************************
  logic deep;
  logic pm9_sel;
  logic wake_any2;
  logic wake_any3;
  logic rst_any;

  assign deep      = ctrl_ff[pmc_pkg::CTRL_DEEP_BIT];
  assign pm9_sel   = ctrl_ff[pmc_pkg::CTRL_POWER_MODE_SELECT_BIT_BIT];
  // Mode 2 keeps bus clocks, so any enabled source wakes, port sources included
  assign wake_any2 = |(wake_sync & wakeen_ff);
  // Mode 3 has no bus clock: only clock-free sources can reach the core
  assign wake_any3 = |(wake_sync & wakeen_ff & pmc_pkg::WAKE_NOBUS_MASK);
  assign rst_any   = |(rst_sync & rsten_ff);

  always_comb begin
    nxt_state  = state_ff;
    nxt_mode   = mode_ff;
    // The pulse is state too: a low clock enable must hold it, not clear it
    nxt_wpulse = clk_en ? 1'b0 : wpulse_ff;
    nxt_rstreq = rstreq_ff;
    if (clk_en) begin
      case (state_ff)
        pmc_pkg::ST_RUN: begin
          // Mode 1 vs 0 follows the RAM execution bit while running
          nxt_mode = ctrl_ff[pmc_pkg::CTRL_RAMX_BIT] ? pmc_pkg::PM1 : pmc_pkg::PM0;
          if (sleep_req) begin
            if (deep && pm9_sel) begin
              nxt_state = pmc_pkg::ST_DEEP9;
            end else if (deep) begin
              nxt_state = pmc_pkg::ST_HALT3;
            end else begin
              nxt_state = pmc_pkg::ST_HALT2;
            end
          end
        end
        pmc_pkg::ST_HALT2: begin
          if (wake_any2 && wake_accept) begin
            nxt_state  = pmc_pkg::ST_WAKE;
            nxt_wpulse = 1'b1;
          end
        end
        pmc_pkg::ST_HALT3: begin
          if (wake_any3 && wake_accept) begin
            nxt_state  = pmc_pkg::ST_WAKE;
            nxt_wpulse = 1'b1;
          end
        end
        pmc_pkg::ST_DEEP9: begin
          // Interrupts are ignored here; only a reset source gets out
          if (rst_any) begin
            nxt_rstreq = 1'b1;
          end
        end
        pmc_pkg::ST_WAKE: begin
          nxt_state = pmc_pkg::ST_RUN;
        end
        default: begin
          nxt_state = pmc_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff  <= pmc_pkg::ST_RUN;
      mode_ff   <= pmc_pkg::PM0;
      wpulse_ff <= 1'b0;
      rstreq_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      mode_ff   <= nxt_mode;
      wpulse_ff <= nxt_wpulse;
      rstreq_ff <= nxt_rstreq;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic bus_run;
  logic halt3;
  logic deep9;

  assign halt3 = (state_ff == pmc_pkg::ST_HALT3);
  assign deep9 = (state_ff == pmc_pkg::ST_DEEP9);
  assign bus_run = ~halt3 & ~deep9;

  always_comb begin
    case (state_ff)
      pmc_pkg::ST_HALT2: power_mode = pmc_pkg::PM2;
      pmc_pkg::ST_HALT3: power_mode = pmc_pkg::PM3;
      pmc_pkg::ST_DEEP9: power_mode = pmc_pkg::PM9;
      default:           power_mode = mode_ff;
    endcase
  end

  assign core_run         = (state_ff == pmc_pkg::ST_RUN) | (state_ff == pmc_pkg::ST_WAKE);
  assign flash_fetch      = core_run & (mode_ff == pmc_pkg::PM0);
  assign ram_fetch_nowait = core_run & (mode_ff == pmc_pkg::PM1);
  assign wake_irq_pulse   = wpulse_ff;
  assign deep_reset_req   = rstreq_ff;
  assign ram_retain_only  = deep9;

  always_comb begin
    clk_ctrl.bus_clk_en     = bus_run;
    clk_ctrl.core_clk_en    = core_run;
    // Fast oscillator suspends in mode 3 and 9
    clk_ctrl.fast_osc_en    = bus_run;
    // Fast wake with the LF select bit keeps the slow clock alive in mode 3
    clk_ctrl.slow_clk_sel   = halt3 & ctrl_ff[pmc_pkg::CTRL_FWAKE_BIT] &
                              ctrl_ff[pmc_pkg::CTRL_LFSEL_BIT];
    clk_ctrl.pins_low_power = deep9;
  end

  pmc_clkgate #(.N(pmc_pkg::NUM_PERIPH)) u_gate (
    .clk           (clk),
    .reset_n       (reset_n),
    .ce            (clk_en),
    .gate_en       (gate_ff),
    .bus_run       (bus_run),
    .periph_clk_en (periph_clk_en)
  );

  // ****************************************
  // Assertions
  // ****************************************
  property p_deep9_stays;
    @(posedge clk) disable iff (!reset_n)
      (deep9 && !rst_any && clk_en) |=> deep9;
  endproperty
  a_deep9_stays: assert property (p_deep9_stays) else $error("Left mode 9 without reset");

  property p_halt3_no_bus;
    @(posedge clk) disable iff (!reset_n)
      halt3 |-> (!clk_ctrl.bus_clk_en && !clk_ctrl.fast_osc_en);
  endproperty
  a_halt3_no_bus: assert property (p_halt3_no_bus) else $error("Bus clock running in mode 3");

  property p_wake_returns;
    @(posedge clk) disable iff (!reset_n)
      (state_ff == pmc_pkg::ST_WAKE && clk_en) |=> (state_ff == pmc_pkg::ST_RUN && core_run);
  endproperty
  a_wake_returns: assert property (p_wake_returns) else $error("Wake did not resume run");

  property p_halt2_sleep;
    @(posedge clk) disable iff (!reset_n)
      (state_ff == pmc_pkg::ST_RUN && sleep_req && !deep && clk_en) |=> (power_mode == pmc_pkg::PM2);
  endproperty
  a_halt2_sleep: assert property (p_halt2_sleep) else $error("Sleep did not enter mode 2");

  property p_halt3_wake_src;
    @(posedge clk) disable iff (!reset_n)
      (halt3 && clk_en && !(wake_any3 && wake_accept)) |=> halt3;
  endproperty
  a_halt3_wake_src: assert property (p_halt3_wake_src) else $error("Mode 3 woke on bus source");

  property p_halt2_wake;
    @(posedge clk) disable iff (!reset_n)
      (state_ff == pmc_pkg::ST_HALT2 && wake_any2 && wake_accept && clk_en) |=> ##1 core_run;
  endproperty
  a_halt2_wake: assert property (p_halt2_wake) else $error("Mode 2 wake missed");

  property p_reject_wake;
    @(posedge clk) disable iff (!reset_n)
      (state_ff == pmc_pkg::ST_HALT2 && !wake_accept && clk_en) |=> !wake_irq_pulse;
  endproperty
  a_reject_wake: assert property (p_reject_wake) else $error("Woke on unaccepted interrupt");

  property p_gate_off;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && !gate_ff[0]) |=> !periph_clk_en[0];
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("Gated clock still enabled");

endmodule : pmc_power_mode_controller

/* hw/pmc_pkg.sv */
// Package of constants and types for the power mode controller
package pmc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_CLKGATE = 12'h004;
  localparam logic [11:0] ADDR_WAKEEN  = 12'h008;
  localparam logic [11:0] ADDR_RSTEN   = 12'h00C;
  localparam logic [11:0] ADDR_STATUS  = 12'h010;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_DEEP_BIT  = 0;
  localparam int CTRL_POWER_MODE_SELECT_BIT_BIT = 1;
  localparam int CTRL_RAMX_BIT  = 2;
  localparam int CTRL_FWAKE_BIT = 3;
  localparam int CTRL_LFSEL_BIT = 4;
  localparam int NUM_PERIPH     = 16;
  localparam int NUM_WAKE       = 10;
  localparam int NUM_RST        = 4;
  localparam logic [4:0]            CTRL_RST    = 5'h00;
  localparam logic [NUM_PERIPH-1:0] CLKGATE_RST = 16'hFFFF;
  localparam logic [NUM_WAKE-1:0]   WAKEEN_RST  = 10'h000;
  localparam logic [NUM_RST-1:0]    RSTEN_RST   = 4'h1;

  // Wake source indices
  localparam int WK_LPT      = 0;
  localparam int WK_TK_ALARM = 1;
  localparam int WK_TK_FAIL  = 2;
  localparam int WK_CMP0     = 3;
  localparam int WK_PINWAKE  = 4;
  localparam int WK_CORE_SUPPLY_LOW_IRQ   = 5;
  localparam int WK_REGULATOR_LOW_IRQ  = 6;
  localparam int WK_PMATCH   = 7;
  localparam int WK_PBEXT_A  = 8;
  localparam int WK_PBEXT_B  = 9;
  // Sources that need no bus clock
  localparam logic [NUM_WAKE-1:0] WAKE_NOBUS_MASK = 10'h067;

  // Power mode codes
  localparam logic [3:0] PM0 = 4'h0;
  localparam logic [3:0] PM1 = 4'h1;
  localparam logic [3:0] PM2 = 4'h2;
  localparam logic [3:0] PM3 = 4'h3;
  localparam logic [3:0] PM9 = 4'h9;

  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_HALT2 = 5'b00010,
    ST_HALT3 = 5'b00100,
    ST_DEEP9 = 5'b01000,
    ST_WAKE  = 5'b10000
  } pmc_state_t;

  typedef struct packed {
    logic bus_clk_en;
    logic fast_osc_en;
    logic slow_clk_sel;
    logic core_clk_en;
    logic pins_low_power;
  } pmc_clk_t;

endpackage : pmc_pkg

/* hw/pmc_sync.sv */
// Two-flop synchroniser, one per bit
`timescale 1ns/1ps
module pmc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_s1;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_s1 = ce ? d : s1_ff;
    nxt_q  = ce ? s1_ff : q_ff;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= '0;
      q_ff  <= '0;
    end else begin
      s1_ff <= nxt_s1;
      q_ff  <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule : pmc_sync

/* hw/pmc_clkgate.sv */
// Per-peripheral clock enable gating
`timescale 1ns/1ps
module pmc_clkgate #(
  parameter int N = 16
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic [N-1:0] gate_en,
  input  wire logic         bus_run,
  output logic      [N-1:0] periph_clk_en
);
  logic [N-1:0] en_ff;
  logic [N-1:0] nxt_en;

  // ****************************************
  // One enable per peripheral
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_gate
      always_comb begin
        nxt_en[i] = ce ? (gate_en[i] & bus_run) : en_ff[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_ff <= '0;
    end else begin
      en_ff <= nxt_en;
    end
  end

  assign periph_clk_en = en_ff;
endmodule : pmc_clkgate

/* verification/pmc_core_model.sv */
// Core-side model: sleep instruction issue and interrupt acceptance
`timescale 1ns/1ps
module pmc_core_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic go,
  input  wire logic acc,
  input  wire logic core_run,
  output logic      sleep_req,
  output logic      wake_accept
);
  int bar_cnt;

  // Pending interrupt priority is only good enough when the bench says so
  assign wake_accept = acc;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bar_cnt   <= 0;
      sleep_req <= 1'b0;
    end else begin
      sleep_req <= 1'b0;
      if (go) begin
        bar_cnt <= 3; // Barriers drain the bus before sleeping
      end else if (bar_cnt > 1) begin
        bar_cnt <= bar_cnt - 1;
      end else if (bar_cnt == 1 && core_run) begin
        bar_cnt   <= 0;
        sleep_req <= 1'b1; // One-cycle sleep instruction after setup
      end
    end
  end
endmodule : pmc_core_model

/* verification/tb.sv */
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb;
  logic              clk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              sleep_req, wake_accept, core_run, flash_fetch, ram_fetch_nowait;
  logic              wake_irq_pulse, deep_reset_req, ram_retain_only, go, acc;
  logic [9:0]        wake_src;
  logic [3:0]        rst_src, power_mode;
  logic [15:0]       periph_clk_en;
  pmc_pkg::pmc_clk_t clk_ctrl;
  int                n_mismatch, num_checks, m_ctrl, m_gate, m_wake, i, s;
  int                nobus[$] = '{0, 1, 2, 5, 6};

  pmc_power_mode_controller i_pmc_power_mode_controller (.clk, .reset_n, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .sleep_req, .wake_accept, .wake_src, .rst_src,
    .core_run, .power_mode, .flash_fetch, .ram_fetch_nowait, .wake_irq_pulse, .deep_reset_req,
    .ram_retain_only, .clk_ctrl, .periph_clk_en);
  pmc_core_model i_pmc_core_model (.clk, .reset_n, .go, .acc, .core_run, .sleep_req, .wake_accept);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      end_sim();
    end
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, d);
    if (a == pmc_pkg::ADDR_CTRL) m_ctrl = d & 'h1F;
    if (a == pmc_pkg::ADDR_CLKGATE) m_gate = d & 'hFFFF;
    if (a == pmc_pkg::ADDR_WAKEEN) m_wake = d & 'h3FF;
  endtask : wr

  task automatic rdc(input logic [11:0] a, input int e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
    chk("pslverr", 0, er);
  endtask : rdc

  function automatic int run_mode();
    return m_ctrl[2];
  endfunction : run_mode

  function automatic int sleep_mode();
    return m_ctrl[0] ? (m_ctrl[1] ? 9 : 3) : 2;
  endfunction : sleep_mode

  task automatic wait_mode(input int e);
    int k;
    for (k = 0; k < 30 && power_mode !== e[3:0]; k++) @(posedge clk);
    chk("power_mode", e, power_mode);
    if (power_mode !== e[3:0]) end_sim();
  endtask : wait_mode

  task automatic nap(input int src, input bit a);
    int e;
    bit wk;
    e  = sleep_mode();
    wk = a && m_wake[src] && (e == 2 || src inside {nobus});
    @(posedge clk);
    go  <= 1'b1;
    acc <= a;
    @(posedge clk);
    go <= 1'b0;
    wait_mode(e);
    @(posedge clk);
    chk("core_run", 0, core_run);
    chk("wake_irq_pulse", 0, wake_irq_pulse);
    chk("bus_clk_en", e == 2, clk_ctrl.bus_clk_en);
    chk("periph_clk_en", (e == 2) ? m_gate : 0, periph_clk_en);
    if (e == 3) begin
      chk("fast_osc_en", 0, clk_ctrl.fast_osc_en);
      chk("slow_clk_sel", m_ctrl[3] & m_ctrl[4], clk_ctrl.slow_clk_sel);
    end
    wake_src[src] <= 1'b1;
    if (wk) begin
      wait_mode(run_mode());
    end else begin
      repeat (20) @(posedge clk);
      chk("power_mode", e, power_mode);
      wake_src[1] <= 1'b1;
      acc <= 1'b1;
      wait_mode(run_mode());
    end
    chk("wake_irq_pulse", 1, wake_irq_pulse);
    chk("flash_fetch", run_mode() == 0, flash_fetch);
    chk("fast_osc_en", 1, clk_ctrl.fast_osc_en);
    wake_src <= '0;
    acc <= 1'b0;
  endtask : nap

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h87B9));
    {clk_en, reset_n, psel, penable, pwrite, go, acc} = 7'h40;
    {paddr, pwdata, wake_src, rst_src} = '0;
    m_ctrl = 0;
    m_gate = 'hFFFF;
    m_wake = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("power_mode", 0, power_mode);
    chk("flash_fetch", 1, flash_fetch);
    rdc(pmc_pkg::ADDR_CTRL, 0);
    rdc(pmc_pkg::ADDR_CLKGATE, 'hFFFF);
    rdc(pmc_pkg::ADDR_WAKEEN, 0);
    rdc(pmc_pkg::ADDR_RSTEN, 1);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    $display("test reset_values done");
    wr(pmc_pkg::ADDR_CLKGATE, $urandom);
    rdc(pmc_pkg::ADDR_CLKGATE, m_gate);
    repeat (2) @(posedge clk);
    chk("periph_clk_en", m_gate, periph_clk_en);
    clk_en <= 1'b0;
    apb(1'b1, pmc_pkg::ADDR_CLKGATE, 32'h0);
    clk_en <= 1'b1;
    rdc(pmc_pkg::ADDR_CLKGATE, m_gate);
    $display("test clock_gating done");
    wr(pmc_pkg::ADDR_CTRL, 'h04);
    wait_mode(1);
    chk("ram_fetch_nowait", 1, ram_fetch_nowait);
    apb(1'b0, pmc_pkg::ADDR_STATUS, 32'h0);
    chk("status_mode", 1, rd[3:0]);
    wr(pmc_pkg::ADDR_WAKEEN, 'h3FF);
    for (s = 0; s < 10; s++) nap(s, 1'b1);
    nap(7, 1'b0);
    $display("test core_halt_mode done");
    wr(pmc_pkg::ADDR_CTRL, 'h19);
    for (s = 0; s < 10; s++) nap(s, 1'b1);
    wr(pmc_pkg::ADDR_CTRL, 'h09);
    wr(pmc_pkg::ADDR_WAKEEN, 'h3FE);
    nap(0, 1'b1);
    nap($urandom_range(9), 1'b1);
    $display("test bus_clock_halt_mode done");
    wr(pmc_pkg::ADDR_RSTEN, 'h2);
    wr(pmc_pkg::ADDR_CTRL, 'h03);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_mode(9);
    @(posedge clk);
    chk("ram_retain_only", 1, ram_retain_only);
    chk("clk_ctrl", 5'h01, clk_ctrl);
    wake_src <= 10'h3FF;
    acc <= 1'b1;
    rst_src <= 4'h1;
    repeat (20) @(posedge clk);
    chk("power_mode", 9, power_mode);
    chk("deep_reset_req", 0, deep_reset_req);
    rst_src <= 4'h2;
    for (i = 0; i < 10 && deep_reset_req !== 1'b1; i++) @(posedge clk);
    chk("deep_reset_req", 1, deep_reset_req);
    if (deep_reset_req !== 1'b1) end_sim();
    reset_n <= 1'b0;
    {wake_src, rst_src, acc} <= '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    m_ctrl = 0;
    @(posedge clk);
    chk("power_mode", 0, power_mode);
    chk("deep_reset_req", 0, deep_reset_req);
    $display("test deepest_reset_exit_mode done");
    end_sim();
  end

  initial begin
    #2000000;
    n_mismatch++;
    end_sim();
  end
endmodule : tb
